// >>> nsm_params.svh
// constants for the status and operating-mode register bank
// assumes a 32-bit register port with byte offsets as the address
`ifndef NSM_PARAMS_SVH
`define NSM_PARAMS_SVH

`define NSM_OFF_STATUS 8'h28
`define NSM_OFF_MODE 8'h30
`define NSM_STATUS_RESET 32'hFC000000
`define NSM_MODE_RESET 32'h00000000

// status bit positions
`define NSM_ST_TX_DONE 0
`define NSM_ST_TX_STOPPED 1
`define NSM_ST_TX_UNAVAIL 2
`define NSM_ST_TX_JABBER 3
`define NSM_ST_FATAL_BUS 13
`define NSM_ST_ABN_SUM 15
`define NSM_ST_NRM_SUM 16
`define NSM_ST_W1C_TOP 16
`define NSM_ST_EB_LSB 23
`define NSM_ST_TS_LSB 20
`define NSM_ST_RS_LSB 17

// operating-mode bit positions
`define NSM_MD_ENH_CAPTURE 31
`define NSM_MD_ACCEPT_ALL 30
`define NSM_MD_FIXED_ONE 25
`define NSM_MD_SCRAMBLER 24
`define NSM_MD_SYMBOL_MODE 23
`define NSM_MD_RATE_SEL 22
`define NSM_MD_WHOLE_FRAME 21
`define NSM_MD_HEARTBEAT_OFF 19
`define NSM_MD_PORT_SEL 18
`define NSM_MD_CAPTURE 17
`define NSM_MD_LEVEL_LSB 14
`define NSM_MD_TX_RUN 13
`define NSM_MD_COLL_FORCE 12
`define NSM_MD_LOOP_LSB 10
`define NSM_MD_DUPLEX 9
`define NSM_MD_RX_RUN 1
// bits software may store; filter bits 4, 2 and 0 read as zero here
`define NSM_MODE_RW_MASK 32'hC3FEFFEA

// transmit thresholds in bytes, 100 Mb/s set then 10 Mb/s set
`define NSM_THR_100_0 11'd72
`define NSM_THR_100_1 11'd96
`define NSM_THR_100_2 11'd128
`define NSM_THR_100_3 11'd160
`define NSM_THR_10_0 11'd128
`define NSM_THR_10_1 11'd256
`define NSM_THR_10_2 11'd512
`define NSM_THR_10_3 11'd1024

// descriptor word zero flag positions and forced-collision attempts
`define NSM_DESC_JABBER 14
`define NSM_DESC_EXCESS_COLL 8
`define NSM_COLL_ATTEMPTS 5'd16

`endif

// >>> nsm_pkg.sv
// types for the status and operating-mode register bank
// assumes nsm_params.svh supplies offsets and bit positions; state and field codes are set here
package nsm_pkg;

    typedef enum logic [6:0] {
        NSM_TX_STOP = 7'h01,
        NSM_TX_FETCH = 7'h02,
        NSM_TX_WAIT_END = 7'h04,
        NSM_TX_FILL = 7'h08,
        NSM_TX_SETUP = 7'h10,
        NSM_TX_SUSP = 7'h20,
        NSM_TX_CLOSE = 7'h40
    } nsm_tx_state_t;

    typedef enum logic [2:0] {
        NSM_TXC_STOPPED = 3'h0,
        NSM_TXC_FETCH = 3'h1,
        NSM_TXC_WAIT_END = 3'h2,
        NSM_TXC_FILL = 3'h3,
        NSM_TXC_SETUP = 3'h5,
        NSM_TXC_SUSPENDED = 3'h6,
        NSM_TXC_CLOSE = 3'h7
    } nsm_tx_code_t;

    typedef enum logic [2:0] {
        NSM_RXC_STOPPED = 3'h0,
        NSM_RXC_FETCH = 3'h1,
        NSM_RXC_CHECK_END = 3'h2,
        NSM_RXC_WAIT_PKT = 3'h3,
        NSM_RXC_SUSPENDED = 3'h4,
        NSM_RXC_CLOSE = 3'h5,
        NSM_RXC_FLUSH = 3'h6,
        NSM_RXC_QUEUE = 3'h7
    } nsm_rx_code_t;

    typedef enum logic [2:0] {
        NSM_BE_PARITY = 3'h0,
        NSM_BE_MASTER_ABORT = 3'h1,
        NSM_BE_TARGET_ABORT = 3'h2
    } nsm_bus_err_t;

    typedef enum logic [1:0] {
        NSM_LOOP_NORMAL = 2'h0,
        NSM_LOOP_INTERNAL = 2'h1,
        NSM_LOOP_EXTERNAL = 2'h2
    } nsm_loop_t;

endpackage : nsm_pkg

// >>> nsm_regs.sv
// status and operating-mode register bank with the transmit process sequencer
// assumes a simple synchronous register port and a transmit datapath giving pulses
`timescale 1ns/10ps
`default_nettype none
`include "nsm_params.svh"

// Summary of operation
// - jabber expiry: flag, abort, stop, descriptor flag
// - host-owned descriptor: flag unavailable, suspend transmit
// - entering stopped sets transmit stopped flag
// - frame done with completion request sets flag
// - bus error code: parity, master, target abort
// - parity error recovers only by software reset
// - transmit state field encodes process state
// - receive state field encodes receive state
// - low status bits write-one-clear, upper ignore writes
// - mode bit 31 enables enhanced capture resolution
// - accept-all receives every packet, match still reported
// - scrambler and symbol mode bits drive port
// - rate select changes only while transmit stopped
// - store-and-forward waits whole frame, changes when stopped
// - port select: hardware reset clears, software keeps
// - threshold: start above level or short whole frame
// - start command from stopped fetches, may suspend
// - stop command ends after frame, keeps position
// - forced collision: sixteen attempts, excess flag
// - full duplex only when both stopped, heartbeat off
// - loopback field: normal, internal, external
// - threshold codes map to byte levels
module nsm_regs (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic soft_reset_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [31:0] tx_list_base_in,
    input wire logic tx_list_base_load_in,
    input wire logic desc_fetch_done_in,
    input wire logic desc_owned_by_device_in,
    input wire logic desc_is_setup_in,
    input wire logic desc_irq_req_in,
    input wire logic [31:0] next_desc_addr_in,
    input wire logic fifo_fill_done_in,
    input wire logic setup_done_in,
    input wire logic tx_end_in,
    input wire logic close_done_in,
    input wire logic poll_demand_in,
    input wire logic auto_poll_in,
    input wire logic tx_jabber_timeout_in,
    input wire logic tx_attempt_in,
    input wire logic bus_error_in,
    input wire logic [2:0] bus_error_type_in,
    input wire logic [14:4] other_status_set_in,
    input wire logic [2:0] rx_state_in,
    input wire logic rx_addr_match_in,
    input wire logic [10:0] fifo_frame_bytes_in,
    input wire logic fifo_frame_complete_in,
    output logic [31:0] tx_desc_addr_out,
    output logic [31:0] tx_desc_word_zero_flags_out,
    output logic tx_abort_out,
    output logic tx_start_ok_out,
    output logic collision_force_out,
    output logic bus_access_enable_out,
    output logic heartbeat_check_out,
    output logic accept_all_packets_out,
    output logic rx_match_report_out,
    output logic enhanced_capture_enable_out,
    output logic capture_resolve_enable_out,
    output logic scrambler_enable_out,
    output logic symbol_mode_out,
    output logic media_port_select_out,
    output logic [1:0] loopback_select_out,
    output logic duplex_full_out,
    output logic [10:0] tx_threshold_bytes_out
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    nsm_pkg::nsm_tx_state_t tx_q, tx_d;
    logic [16:0] sts_q;
    logic [16:0] sts_set;
    logic [16:0] sts_clr;
    logic [2:0] eb_q;
    logic parity_lock_q;
    logic [31:0] mode_q;
    logic [31:0] mode_d;
    logic stop_pend_q;
    logic base_fresh_q;
    logic [31:2] desc_ptr_q;
    logic [31:0] desc_flags_q;
    logic [4:0] coll_cnt_q;
    logic abort_q;
    logic match_q;
    logic [31:0] rdata_q;
    logic wr_status;
    logic wr_mode;
    logic tx_stopped;
    logic rx_stopped;
    logic start_cmd;
    logic stop_cmd;
    logic enter_stop;
    logic jabber;
    logic fc_active;
    logic [15:0] status_low;

    function automatic logic [2:0] tx_code(input nsm_pkg::nsm_tx_state_t s);
        unique case (s)
            nsm_pkg::NSM_TX_STOP: tx_code = nsm_pkg::NSM_TXC_STOPPED;
            nsm_pkg::NSM_TX_FETCH: tx_code = nsm_pkg::NSM_TXC_FETCH;
            nsm_pkg::NSM_TX_WAIT_END: tx_code = nsm_pkg::NSM_TXC_WAIT_END;
            nsm_pkg::NSM_TX_FILL: tx_code = nsm_pkg::NSM_TXC_FILL;
            nsm_pkg::NSM_TX_SETUP: tx_code = nsm_pkg::NSM_TXC_SETUP;
            nsm_pkg::NSM_TX_SUSP: tx_code = nsm_pkg::NSM_TXC_SUSPENDED;
            nsm_pkg::NSM_TX_CLOSE: tx_code = nsm_pkg::NSM_TXC_CLOSE;
            default: tx_code = nsm_pkg::NSM_TXC_STOPPED;
        endcase
    endfunction : tx_code

    function automatic logic [10:0] level_bytes(input logic rate10, input logic [1:0] lvl);
        unique case ({rate10, lvl})
            3'h0: level_bytes = `NSM_THR_100_0;
            3'h1: level_bytes = `NSM_THR_100_1;
            3'h2: level_bytes = `NSM_THR_100_2;
            3'h3: level_bytes = `NSM_THR_100_3;
            3'h4: level_bytes = `NSM_THR_10_0;
            3'h5: level_bytes = `NSM_THR_10_1;
            3'h6: level_bytes = `NSM_THR_10_2;
            default: level_bytes = `NSM_THR_10_3;
        endcase
    endfunction : level_bytes

    ////////////////////////////////////////////////////////////////////////////
    // decode and command detection

    assign wr_status = reg_wr_in && (reg_addr_in == `NSM_OFF_STATUS);
    assign wr_mode = reg_wr_in && (reg_addr_in == `NSM_OFF_MODE);
    assign tx_stopped = (tx_q == nsm_pkg::NSM_TX_STOP);
    assign rx_stopped = (rx_state_in == nsm_pkg::NSM_RXC_STOPPED);
    // start is honoured only from stopped; stop only from running or suspended
    assign start_cmd = wr_mode && reg_wdata_in[`NSM_MD_TX_RUN] && tx_stopped;
    assign stop_cmd = wr_mode && !reg_wdata_in[`NSM_MD_TX_RUN] && !tx_stopped;
    assign jabber = tx_jabber_timeout_in && !tx_stopped;
    assign enter_stop = !tx_stopped && (tx_d == nsm_pkg::NSM_TX_STOP);

    ////////////////////////////////////////////////////////////////////////////
    // transmit process sequencer

    always_comb begin
        tx_d = tx_q;
        unique case (tx_q)
            nsm_pkg::NSM_TX_STOP: begin
                if (start_cmd) begin
                    tx_d = nsm_pkg::NSM_TX_FETCH;
                end
            end
            nsm_pkg::NSM_TX_FETCH: begin
                if (desc_fetch_done_in) begin
                    if (!desc_owned_by_device_in) begin
                        tx_d = nsm_pkg::NSM_TX_SUSP;
                    end else if (desc_is_setup_in) begin
                        tx_d = nsm_pkg::NSM_TX_SETUP;
                    end else begin
                        tx_d = nsm_pkg::NSM_TX_FILL;
                    end
                end
            end
            nsm_pkg::NSM_TX_FILL: begin
                if (fifo_fill_done_in) begin
                    tx_d = nsm_pkg::NSM_TX_WAIT_END;
                end
            end
            nsm_pkg::NSM_TX_SETUP: begin
                if (setup_done_in) begin
                    tx_d = nsm_pkg::NSM_TX_CLOSE;
                end
            end
            nsm_pkg::NSM_TX_WAIT_END: begin
                if (tx_end_in) begin
                    tx_d = nsm_pkg::NSM_TX_CLOSE;
                end
            end
            nsm_pkg::NSM_TX_CLOSE: begin
                if (close_done_in) begin
                    tx_d = (stop_pend_q || stop_cmd) ? nsm_pkg::NSM_TX_STOP : nsm_pkg::NSM_TX_FETCH;
                end
            end
            nsm_pkg::NSM_TX_SUSP: begin
                if (stop_pend_q || stop_cmd) begin
                    tx_d = nsm_pkg::NSM_TX_STOP;
                end else if (poll_demand_in || auto_poll_in) begin
                    tx_d = nsm_pkg::NSM_TX_FETCH;
                end
            end
            default: tx_d = nsm_pkg::NSM_TX_STOP;
        endcase
        if (jabber) begin
            tx_d = nsm_pkg::NSM_TX_STOP;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_q <= nsm_pkg::NSM_TX_STOP;
        end else if (soft_reset_in) begin
            tx_q <= nsm_pkg::NSM_TX_STOP;
        end else begin
            tx_q <= tx_d;
        end
    end

    // a stop in mid-frame waits for the descriptor close so the frame is not torn
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stop_pend_q <= 1'b0;
        end else if (soft_reset_in || tx_d == nsm_pkg::NSM_TX_STOP) begin
            stop_pend_q <= 1'b0;
        end else if (stop_cmd) begin
            stop_pend_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor position: base after a fresh load, else the retained position

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            base_fresh_q <= 1'b0;
            desc_ptr_q <= 30'h00000000;
        end else if (soft_reset_in) begin
            base_fresh_q <= 1'b0;
            desc_ptr_q <= 30'h00000000;
        end else if (tx_list_base_load_in && tx_stopped) begin
            base_fresh_q <= 1'b1;
            desc_ptr_q <= tx_list_base_in[31:2];
        end else if (start_cmd) begin
            base_fresh_q <= 1'b0;
        end else if (tx_q == nsm_pkg::NSM_TX_CLOSE && close_done_in) begin
            desc_ptr_q <= next_desc_addr_in[31:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor word zero flags and forced collisions

    assign fc_active = mode_q[`NSM_MD_COLL_FORCE]
        && (mode_q[`NSM_MD_LOOP_LSB +: 2] == nsm_pkg::NSM_LOOP_INTERNAL);

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            desc_flags_q <= 32'h00000000;
            coll_cnt_q <= 5'h00;
        end else if (soft_reset_in || tx_d == nsm_pkg::NSM_TX_FETCH) begin
            desc_flags_q <= 32'h00000000;
            coll_cnt_q <= 5'h00;
        end else begin
            if (jabber) begin
                desc_flags_q[`NSM_DESC_JABBER] <= 1'b1;
            end
            if (tx_attempt_in && fc_active && coll_cnt_q != `NSM_COLL_ATTEMPTS) begin
                coll_cnt_q <= coll_cnt_q + 5'h01;
                if (coll_cnt_q == `NSM_COLL_ATTEMPTS - 5'h01) begin
                    desc_flags_q[`NSM_DESC_EXCESS_COLL] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= jabber;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags: set wins over a same-cycle clear

    always_comb begin
        sts_set = 17'h00000;
        sts_set[14:4] = other_status_set_in;
        sts_set[`NSM_ST_FATAL_BUS] = bus_error_in;
        sts_set[`NSM_ST_TX_DONE] = (tx_q == nsm_pkg::NSM_TX_WAIT_END) && tx_end_in && desc_irq_req_in;
        sts_set[`NSM_ST_TX_STOPPED] = enter_stop;
        sts_set[`NSM_ST_TX_UNAVAIL] = (tx_q == nsm_pkg::NSM_TX_FETCH) && desc_fetch_done_in
            && !desc_owned_by_device_in;
        sts_set[`NSM_ST_TX_JABBER] = jabber;
        sts_set[`NSM_ST_ABN_SUM] = 1'b0;
        sts_set[`NSM_ST_NRM_SUM] = 1'b0;
        sts_clr = wr_status ? reg_wdata_in[`NSM_ST_W1C_TOP:0] : 17'h00000;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sts_q <= 17'h00000;
        end else if (soft_reset_in) begin
            sts_q <= 17'h00000;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end

    // the code is held with the flag; a parity error also locks out the bus
    // until software reset, since nothing else can tell a clean recovery
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            eb_q <= 3'h0;
            parity_lock_q <= 1'b0;
        end else if (soft_reset_in) begin
            eb_q <= 3'h0;
            parity_lock_q <= 1'b0;
        end else if (bus_error_in) begin
            eb_q <= bus_error_type_in;
            if (bus_error_type_in == nsm_pkg::NSM_BE_PARITY) begin
                parity_lock_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operating-mode register

    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = reg_wdata_in & `NSM_MODE_RW_MASK;
            if (!tx_stopped) begin
                mode_d[`NSM_MD_RATE_SEL] = mode_q[`NSM_MD_RATE_SEL];
                mode_d[`NSM_MD_WHOLE_FRAME] = mode_q[`NSM_MD_WHOLE_FRAME];
                mode_d[`NSM_MD_LEVEL_LSB +: 2] = mode_q[`NSM_MD_LEVEL_LSB +: 2];
            end
            // duplex may rise only with both processes and both run bits idle
            if (!mode_q[`NSM_MD_DUPLEX] && !(tx_stopped && rx_stopped && !mode_q[`NSM_MD_TX_RUN]
                && !mode_q[`NSM_MD_RX_RUN] && !reg_wdata_in[`NSM_MD_TX_RUN]
                && !reg_wdata_in[`NSM_MD_RX_RUN])) begin
                mode_d[`NSM_MD_DUPLEX] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_q <= `NSM_MODE_RESET;
        end else if (soft_reset_in) begin
            mode_q <= `NSM_MODE_RESET;
            mode_q[`NSM_MD_PORT_SEL] <= mode_q[`NSM_MD_PORT_SEL];
        end else begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, one cycle latency

    assign status_low[14:0] = sts_q[14:0];
    assign status_low[`NSM_ST_ABN_SUM] = sts_q[1] | sts_q[3] | sts_q[5] | sts_q[7] | sts_q[8] | sts_q[9]
        | sts_q[10];

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd_in) begin
            if (reg_addr_in == `NSM_OFF_STATUS) begin
                rdata_q <= {6'(`NSM_STATUS_RESET >> 26), eb_q, tx_code(tx_q), rx_state_in,
                    sts_q[0] | sts_q[2] | sts_q[6] | sts_q[11] | sts_q[14], status_low};
            end else if (reg_addr_in == `NSM_OFF_MODE) begin
                rdata_q <= mode_q;
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            match_q <= 1'b0;
        end else begin
            match_q <= rx_addr_match_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_out = rdata_q;
    assign tx_desc_addr_out = {desc_ptr_q, 2'b00};
    assign tx_desc_word_zero_flags_out = desc_flags_q;
    assign tx_abort_out = abort_q;
    assign tx_threshold_bytes_out = level_bytes(mode_q[`NSM_MD_RATE_SEL], mode_q[`NSM_MD_LEVEL_LSB +: 2]);
    // store-and-forward ignores the level entirely
    assign tx_start_ok_out = mode_q[`NSM_MD_WHOLE_FRAME] ? fifo_frame_complete_in
        : (fifo_frame_bytes_in > tx_threshold_bytes_out) || fifo_frame_complete_in;
    assign collision_force_out = fc_active && !mode_q[`NSM_MD_DUPLEX];
    assign bus_access_enable_out = !sts_q[`NSM_ST_FATAL_BUS] && !parity_lock_q;
    assign heartbeat_check_out = !mode_q[`NSM_MD_DUPLEX] && !mode_q[`NSM_MD_HEARTBEAT_OFF];
    assign accept_all_packets_out = mode_q[`NSM_MD_ACCEPT_ALL];
    assign rx_match_report_out = match_q;
    assign enhanced_capture_enable_out = mode_q[`NSM_MD_ENH_CAPTURE];
    assign capture_resolve_enable_out = mode_q[`NSM_MD_CAPTURE];
    assign scrambler_enable_out = mode_q[`NSM_MD_SCRAMBLER];
    assign symbol_mode_out = mode_q[`NSM_MD_SYMBOL_MODE];
    assign media_port_select_out = mode_q[`NSM_MD_PORT_SEL];
    assign loopback_select_out = mode_q[`NSM_MD_LOOP_LSB +: 2];
    assign duplex_full_out = mode_q[`NSM_MD_DUPLEX];

endmodule : nsm_regs
`default_nettype wire

// >>> nsm_regs_props.sv
// checker for the status and mode register bank
// assumes it is bound to nsm_regs and sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "nsm_params.svh"
module nsm_regs_chk (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic soft_reset_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [2:0] rx_state_in,
    input wire logic rx_addr_match_in,
    input wire logic rx_match_report_out,
    input wire logic tx_jabber_timeout_in,
    input wire logic tx_abort_out,
    input wire logic bus_error_in,
    input wire logic [2:0] bus_error_type_in,
    input wire logic bus_access_enable_out,
    input wire logic collision_force_out,
    input wire logic [1:0] loopback_select_out,
    input wire logic duplex_full_out,
    input wire logic heartbeat_check_out,
    input wire logic fifo_frame_complete_in,
    input wire logic tx_start_ok_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    ////////////////
    sequence s_status_read;
        reg_rd_in && reg_addr_in == `NSM_OFF_STATUS;
    endsequence
    sequence s_parity;
        bus_error_in && bus_error_type_in == 3'h0 && !soft_reset_in;
    endsequence
    property p_abort;
        $rose(tx_abort_out) |-> $past(tx_jabber_timeout_in);
    endproperty
    property p_lock;
        s_parity ##1 !soft_reset_in |-> !bus_access_enable_out;
    endproperty
    property p_top;
        s_status_read |=> reg_rdata_out[31:26] == 6'h3F;
    endproperty
    property p_rx;
        s_status_read |=> reg_rdata_out[19:17] == $past(rx_state_in);
    endproperty
    property p_coll;
        collision_force_out |-> loopback_select_out == 2'h1 && !duplex_full_out;
    endproperty
    property p_hb;
        duplex_full_out |-> !heartbeat_check_out;
    endproperty
    property p_match;
        $past(arst_n_in) |-> rx_match_report_out == $past(rx_addr_match_in);
    endproperty
    property p_whole;
        fifo_frame_complete_in |-> tx_start_ok_out;
    endproperty
    a_abort: assert property (p_abort) else $error("abort without jabber");
    a_lock: assert property (p_lock) else $error("bus open after parity error");
    a_top: assert property (p_top) else $error("status top bits wrong");
    a_rx: assert property (p_rx) else $error("rx state field wrong");
    a_coll: assert property (p_coll) else $error("collision force off mode");
    a_hb: assert property (p_hb) else $error("heartbeat on in duplex");
    a_match: assert property (p_match) else $error("match report wrong");
    a_whole: assert property (p_whole) else $error("whole frame not started");
endmodule : nsm_regs_chk
bind nsm_regs nsm_regs_chk u_chk (.*);
`default_nettype wire

// >>> nsm_host.sv
// host driver model on the strobe register port
// assumes the bench calls wr and rd one at a time
`timescale 1ns/10ps
`default_nettype none
`include "nsm_params.svh"
module nsm_host (
    input wire logic ref_clk_in,
    input wire logic [31:0] rdata_in,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0,
    output logic [7:0] addr_out = 8'h00,
    output logic [31:0] wdata_out = 32'h0
);
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(negedge ref_clk_in);
        addr_out = a;
        wdata_out = (a == `NSM_OFF_MODE) ? (w | 32'h02000000) : w;
        wr_out = 1'b1;
        @(negedge ref_clk_in);
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(negedge ref_clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge ref_clk_in);
        rd_out = 1'b0;
        r = rdata_in;
    endtask : rd
endmodule : nsm_host
`default_nettype wire

// >>> tb_nic_status_mode_registers.sv
// self-checking bench for the status and mode register bank
// assumes nsm_host owns the register port
`timescale 1ns/10ps
`default_nettype none
`include "nsm_params.svh"
module tb_nic_status_mode_registers;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [6:0] ev_v = 7'h00;
    wire logic desc_fetch_done_in, poll_demand_in, fifo_fill_done_in, tx_end_in;
    wire logic tx_jabber_timeout_in, bus_error_in, soft_reset_in;
    logic desc_owned_by_device_in = 1'b0, desc_irq_req_in = 1'b0, auto_poll_in = 1'b0;
    logic desc_is_setup_in = 1'b0, setup_done_in = 1'b0, close_done_in = 1'b0;
    logic tx_list_base_load_in, rx_addr_match_in, fifo_frame_complete_in, tx_attempt_in;
    logic [31:0] reg_rdata_out, tx_desc_addr_out, tx_desc_word_zero_flags_out, reg_wdata_in, rnd, v, d;
    logic [31:0] tx_list_base_in, next_desc_addr_in;
    logic [10:0] fifo_frame_bytes_in, tx_threshold_bytes_out;
    logic [7:0] reg_addr_in;
    logic [2:0] bus_error_type_in = 3'h0, rx_state_in = 3'h0;
    logic [1:0] loopback_select_out;
    logic [14:4] other_status_set_in = 11'h000;
    logic reg_wr_in, reg_rd_in, tx_abort_out, tx_start_ok_out, collision_force_out, bus_access_enable_out;
    logic heartbeat_check_out, accept_all_packets_out, rx_match_report_out, enhanced_capture_enable_out;
    logic capture_resolve_enable_out, scrambler_enable_out, symbol_mode_out, media_port_select_out, duplex_full_out;
    int lo, txc, eb, n_errors, num_checks;
    int seed = 32'h309d;
    int thr [8] = '{72, 96, 128, 160, 128, 256, 512, 1024};
    assign {soft_reset_in, bus_error_in, tx_jabber_timeout_in, tx_end_in, fifo_fill_done_in, poll_demand_in,
        desc_fetch_done_in} = ev_v;
    nsm_regs u_dut (.*);
    nsm_host u_host (.ref_clk_in(ref_clk_in), .rdata_in(reg_rdata_out), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
    always #5 ref_clk_in = ~ref_clk_in;
    ////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk_st();
        u_host.rd(`NSM_OFF_STATUS, d);
        cmp(d, 32'hFC000000 | eb << 23 | txc << 20 | rx_state_in << 17 | ((lo & 32'h7AA) != 0) << 15
            | ((lo & 32'h4845) != 0) << 16 | lo);
    endtask : chk_st
    task automatic pulse(input logic [6:0] m);
        @(negedge ref_clk_in);
        ev_v = m;
        @(negedge ref_clk_in);
        ev_v = 7'h00;
    endtask : pulse
    task automatic step(input logic [6:0] m, input int t, input int b);
        pulse(m);
        txc = t;
        lo = lo | b;
        chk_st();
    endtask : step
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    ////////////////
    initial forever begin
        rnd = $random(seed);
        {tx_list_base_load_in, tx_attempt_in, rx_addr_match_in, fifo_frame_complete_in} = rnd[3:0];
        fifo_frame_bytes_in = rnd[14:4];
        tx_list_base_in = {rnd[31:2], 2'h0};
        next_desc_addr_in = {rnd[29:0], 2'h0};
        @(negedge ref_clk_in);
    end
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        arst_n_in = 1'b1;
        rx_state_in = 3'h5;
        chk_st();
        u_host.wr(`NSM_OFF_MODE, 32'h00002000);
        txc = 1;
        chk_st();
        step(7'h01, 6, 4);
        step(7'h02, 1, 0);
        desc_owned_by_device_in = 1'b1;
        desc_irq_req_in = 1'b1;
        step(7'h01, 3, 0);
        step(7'h04, 2, 0);
        step(7'h08, 7, 1);
        step(7'h10, 0, 10);
        cmp(tx_desc_word_zero_flags_out & 32'h4000, 32'h4000);
        u_host.wr(`NSM_OFF_STATUS, 32'hFFFFFFFF);
        lo = 0;
        chk_st();
        bus_error_type_in = 3'h1;
        eb = 1;
        step(7'h20, 0, 32'h2000);
        lo = 0;
        eb = 0;
        step(7'h40, 0, 0);
        bus_error_type_in = 3'h0;
        pulse(7'h20);
        cmp({31'h0, bus_access_enable_out}, 32'h0);
        pulse(7'h40);
        cmp({31'h0, bus_access_enable_out}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            u_host.wr(`NSM_OFF_MODE, {9'h0, i[2], 6'h0, i[1:0], 14'h0});
            cmp({21'h0, tx_threshold_bytes_out}, thr[i]);
        end
        v = $random(seed) & 32'hC3FEDDE8 | 32'h02000000;
        u_host.wr(`NSM_OFF_MODE, v);
        u_host.rd(`NSM_OFF_MODE, d);
        cmp(d, v);
        cmp({26'h0, accept_all_packets_out, enhanced_capture_enable_out, scrambler_enable_out, symbol_mode_out,
            media_port_select_out, capture_resolve_enable_out}, {26'h0, v[30], v[31], v[24:23], v[18:17]});
        pulse(7'h40);
        u_host.rd(`NSM_OFF_MODE, d);
        cmp(d, v & 32'h00040000);
        rx_state_in = 3'h0;
        u_host.wr(`NSM_OFF_MODE, 32'h00000200);
        cmp({30'h0, duplex_full_out, heartbeat_check_out}, 32'h2);
        u_host.wr(`NSM_OFF_MODE, 32'h00001400);
        cmp({29'h0, collision_force_out, loopback_select_out}, 32'h5);
        repeat (99) @(negedge ref_clk_in);
        cmp(tx_desc_word_zero_flags_out & 32'h100, 32'h100);
        summarize();
    end
endmodule : tb_nic_status_mode_registers
`default_nettype wire
